// ===== overload_inverse_time_limiter.sv
// How it works
// - While motor current is above the overload threshold (50.00..150.00 %, default 105.00 %) the excess is summed each tick.
// - The limit stays at the nominal ceiling until the hold span is used up, and only then starts to fall.
// - The hold span (5.0..60.0 s, default 60.0 s) is the longest time a 150.0 % current is tolerated.
// - After the hold the limit ramps down to the threshold at a rate set by the down time (1.0..10.0 s, default 10.0 s).
// - When the overload clears the limit ramps back to the ceiling at a rate set by the up time (1.0..600.0 s, default 120.0 s).
// - In fan/pump load mode the tolerated overload is 110.0 % for 60.0 s before any reduction.
// - The active flag is high while the reduced limit acts and low otherwise, and low after reset.
// - The present limit level is reported continuously as a percentage.
`timescale 1ns/1ps
module overload_inverse_time_limiter
  import overload_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [15:0] motor_current,
  input  wire logic [15:0] nominal_current_ceiling,
  input  wire logic        fan_pump_load_mode,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic      [15:0] reduced_limit_level,
  output logic             limit_reduction_active,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Control tick divider
  //
  // Every slow process below moves only on the one-cycle tick, so all time
  // constants are counted in ticks rather than clock cycles. The default
  // divider gives a 1 ms tick from the 40 MHz clock; a bench may shrink it
  // to shorten runs, and every duration then scales with it.
  // The counter is 32 bits wide so that a much slower tick still fits.

  logic [31:0] tick_count;
  logic        tick;

  // One-cycle enable for every slow-rate process below
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else if (tick_count >= 32'(TICK_DIV - 1)) begin
      tick_count <= '0;
      tick       <= 1'b1;
    end else begin
      tick_count <= tick_count + 32'h0000_0001;
      tick       <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  //
  // Four tuning values plus the interrupt enable live here. Percentages are
  // held in units of 0.01 % and times in units of 0.1 s, both as plain
  // unsigned 16-bit words.
  // Each write of a tuning value is clamped to its legal range instead of being refused. This
  // way software always reads back what the hardware really uses, and a
  // duration of zero, which would give a divide by zero in the step logic,
  // can never reach the ramps.

  logic [15:0]          overload_threshold;
  logic [15:0]          overload_hold_period;
  logic [15:0]          ramp_down_duration;
  logic [15:0]          recovery_ramp_duration;
  logic [EVT_COUNT-1:0] irq_enable;

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Out-of-range writes are clamped so the ramps never see a zero duration
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      overload_threshold     <= THRESHOLD_RESET;
      overload_hold_period   <= HOLD_RESET;
      ramp_down_duration     <= DOWN_RESET;
      recovery_ramp_duration <= UP_RESET;
      irq_enable             <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_THRESHOLD:  overload_threshold <= clamp16(reg_wdata, THRESHOLD_MIN, THRESHOLD_MAX);
        REG_HOLD:       overload_hold_period <= clamp16(reg_wdata, HOLD_MIN, HOLD_MAX);
        REG_DOWN_TIME:  ramp_down_duration <= clamp16(reg_wdata, DOWN_MIN, DOWN_MAX);
        REG_UP_TIME:    recovery_ramp_duration <= clamp16(reg_wdata, UP_MIN, UP_MAX);
        REG_IRQ_ENABLE: irq_enable <= reg_wdata[EVT_COUNT-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overload budget and ramp steps
  //
  // The budget is the summed excess that a peak current would build up over
  // the whole hold span. Any smaller overload therefore lasts longer before
  // the limit starts to fall, which gives the inverse-time shape.
  // Fan/pump mode swaps in a lower peak and a fixed hold, so that a
  // quadratic load gets only a small, fixed overload allowance.
  // Both ramp steps come from one integer divide of the span by the ramp
  // length in ticks. A long ramp over a narrow span would round the step to
  // zero, so the step is forced to at least one unit. The ramp then ends
  // early instead of stalling forever.
  // The divides are combinational. They only see the ceiling input and
  // register values, which change rarely, so their depth is a timing cost and not a hazard.

  logic [15:0] peak_level;
  logic [15:0] hold_tenths;
  logic [15:0] floor_level;
  logic [15:0] hold_ticks;
  logic [15:0] peak_excess;
  logic [31:0] overload_budget;
  logic [31:0] down_ticks;
  logic [31:0] up_ticks;
  logic [15:0] span;
  logic [15:0] down_step;
  logic [15:0] up_step;
  logic        overloaded;

  // Fan/pump mode swaps the tolerated peak and the hold span
  assign peak_level  = fan_pump_load_mode ? PEAK_FAN_PUMP : PEAK_NORMAL;
  assign hold_tenths = fan_pump_load_mode ? HOLD_FAN_PUMP : overload_hold_period;
  assign hold_ticks  = 16'(32'(hold_tenths) * TICKS_PER_TENTH);
  assign peak_excess = (peak_level > overload_threshold) ? 16'(peak_level - overload_threshold) : 16'h0001;
  // Budget equals the area of a peak current held for the whole span
  assign overload_budget = 32'(peak_excess) * 32'(hold_ticks);
  assign overloaded  = motor_current > overload_threshold;

  // A ceiling below the threshold pulls the floor down with it
  assign floor_level = (nominal_current_ceiling < overload_threshold) ? nominal_current_ceiling : overload_threshold;
  assign span        = 16'(nominal_current_ceiling - floor_level);
  assign down_ticks  = 32'(ramp_down_duration) * TICKS_PER_TENTH;
  assign up_ticks    = 32'(recovery_ramp_duration) * TICKS_PER_TENTH;

  // Step sizes; a step of at least one unit keeps a short span moving
  always_comb begin
    down_step = 16'(32'(span) / down_ticks);
    up_step   = 16'(32'(span) / up_ticks);
    if (down_step == 16'h0000) begin
      down_step = 16'h0001;
    end
    if (up_step == 16'h0000) begin
      up_step = 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Excess-current integrator
  //
  // Above the threshold the excess over it is added on every tick. Below the
  // threshold the shortfall is taken off again, so short bursts of overload
  // do not add up over a long run.
  // The sum saturates at the budget. This keeps it from wrapping, and it
  // bounds how long recovery takes once the load drops.
  // A current that sits exactly on the threshold neither adds nor drains,
  // so a motor held on the floor keeps the budget spent.
  // The sum is 32 bits wide; the largest budget is well inside that.

  logic [31:0] excess_sum;
  logic [31:0] excess_in;
  logic [31:0] deficit_in;
  logic        budget_spent;

  assign excess_in    = overloaded ? 32'(motor_current - overload_threshold) : 32'h0000_0000;
  assign deficit_in   = overloaded ? 32'h0000_0000 : 32'(overload_threshold - motor_current);
  assign budget_spent = excess_sum >= overload_budget;

  // Sum saturates at the budget and bleeds off while below the threshold
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      excess_sum <= '0;
    end else if (tick) begin
      if (overloaded) begin
        excess_sum <= ((excess_sum + excess_in) > overload_budget) ? overload_budget : excess_sum + excess_in;
      end else if (excess_sum > deficit_in) begin
        excess_sum <= excess_sum - deficit_in;
      end else begin
        excess_sum <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit state machine
  //
  // Normal:    the limit tracks the nominal ceiling.
  // Ramp down: one down step per tick until the floor is reached.
  // At floor:  the limit is held at the floor while the overload stays.
  // Recover:   one up step per tick back to the ceiling.
  // Overload returning during recovery with the budget still spent sends
  // the machine straight back to ramping down, without a new hold span.
  // Events are one-cycle pulses that feed the sticky interrupt bits.
  // The floor is never above the ceiling. This keeps a low ceiling from
  // making the ramp step upward.
  // The up-ramp end test is made on a 17-bit sum so that a large limit plus
  // the up step cannot wrap past 16 bits.

  limiter_state_t       state;
  logic [15:0]          limit;
  logic [EVT_COUNT-1:0] events;

  // Limit follows the ceiling until the budget runs out
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state  <= ST_NORMAL;
      limit  <= '0;
      events <= '0;
    end else begin
      events <= '0;
      unique case (state)
        ST_NORMAL: begin
          limit <= nominal_current_ceiling;
          if (tick && budget_spent && overloaded) begin
            state                 <= ST_RAMP_DOWN;
            events[EVT_START_BIT] <= 1'b1;
          end
        end
        ST_RAMP_DOWN: begin
          if (tick) begin
            if (!overloaded) begin
              state <= ST_RECOVER;
            end else if (limit <= floor_level + down_step) begin
              limit                 <= floor_level;
              state                 <= ST_AT_FLOOR;
              events[EVT_FLOOR_BIT] <= 1'b1;
            end else begin
              limit <= limit - down_step;
            end
          end
        end
        ST_AT_FLOOR: begin
          limit <= floor_level;
          if (tick && !overloaded) begin
            state <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (tick) begin
            if (overloaded && budget_spent) begin
              state <= ST_RAMP_DOWN;
            end else if (17'(limit) + 17'(up_step) >= 17'(nominal_current_ceiling)) begin
              limit                   <= nominal_current_ceiling;
              state                   <= ST_NORMAL;
              events[EVT_RECOVER_BIT] <= 1'b1;
            end else begin
              limit <= limit + up_step;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  //
  // Both outputs come straight from flip-flops. They lag the internal state
  // by one cycle, which the current controller does not notice at tick rate.
  // The active flag is high in every state except normal, recovery included.

  // Registered so the current controller sees a clean value
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      limit_reduction_active <= 1'b0;
      reduced_limit_level    <= '0;
    end else begin
      limit_reduction_active <= state != ST_NORMAL;
      reduced_limit_level    <= limit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status
  //
  // Three sticky bits: limiting started, floor reached, fully recovered.
  // Software clears them by writing ones to the clear index.
  // An event that arrives in the same cycle as a clear is kept, so no edge
  // is lost to a racing clear.

  logic [EVT_COUNT-1:0] irq_status;
  logic [EVT_COUNT-1:0] irq_clear;

  assign irq_clear = (reg_wr && reg_addr == REG_IRQ_CLEAR) ? reg_wdata[EVT_COUNT-1:0] : '0;

  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | events;
    end
  end

  // Level output, one cycle behind the status bits
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  //
  // Read data stand only in the cycle after the strobe and are zero
  // otherwise. The bus can then be ORed with other slaves without muxing.
  // The status word shows the active flag, the mode and the spent budget.

  logic [15:0] status_word;

  always_comb begin
    status_word                    = '0;
    status_word[STATUS_ACTIVE_BIT] = limit_reduction_active;
    status_word[STATUS_FAN_BIT]    = fan_pump_load_mode;
    status_word[STATUS_HOLD_BIT]   = budget_spent;
  end

  // Data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_THRESHOLD:  reg_rdata <= overload_threshold;
        REG_HOLD:       reg_rdata <= overload_hold_period;
        REG_DOWN_TIME:  reg_rdata <= ramp_down_duration;
        REG_UP_TIME:    reg_rdata <= recovery_ramp_duration;
        REG_STATUS:     reg_rdata <= status_word;
        REG_LEVEL:      reg_rdata <= reduced_limit_level;
        REG_IRQ_STATUS: reg_rdata <= 16'(irq_status);
        REG_IRQ_ENABLE: reg_rdata <= 16'(irq_enable);
        default:        reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// ===== overload_pkg.sv
package overload_pkg;

  // Clock and control tick
  localparam int CLK_HZ             = 40_000_000;
  localparam int TICK_PERIOD_US     = 1000;
  localparam int TICK_CYCLES        = CLK_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int TICKS_PER_TENTH    = 100_000 / TICK_PERIOD_US;

  // Percent values are in units of 0.01 %
  localparam logic [15:0] THRESHOLD_RESET = 16'h2904;  // 105.00 %
  localparam logic [15:0] THRESHOLD_MIN   = 16'h1388;  // 50.00 %
  localparam logic [15:0] THRESHOLD_MAX   = 16'h3A98;  // 150.00 %
  localparam logic [15:0] PEAK_NORMAL     = 16'h3A98;  // 150.00 % tolerated for the hold
  localparam logic [15:0] PEAK_FAN_PUMP   = 16'h2AF8;  // 110.00 % tolerated in fan/pump mode

  // Times are in units of 0.1 s
  localparam logic [15:0] HOLD_RESET      = 16'h0258;  // 60.0 s
  localparam logic [15:0] HOLD_MIN        = 16'h0032;  // 5.0 s
  localparam logic [15:0] HOLD_MAX        = 16'h0258;  // 60.0 s
  localparam logic [15:0] HOLD_FAN_PUMP   = 16'h0258;  // 60.0 s
  localparam logic [15:0] DOWN_RESET      = 16'h0064;  // 10.0 s
  localparam logic [15:0] DOWN_MIN        = 16'h000A;  // 1.0 s
  localparam logic [15:0] DOWN_MAX        = 16'h0064;  // 10.0 s
  localparam logic [15:0] UP_RESET        = 16'h04B0;  // 120.0 s
  localparam logic [15:0] UP_MIN          = 16'h000A;  // 1.0 s
  localparam logic [15:0] UP_MAX          = 16'h1770;  // 600.0 s

  // Register indices
  localparam logic [3:0] REG_THRESHOLD  = 4'h0;
  localparam logic [3:0] REG_HOLD       = 4'h1;
  localparam logic [3:0] REG_DOWN_TIME  = 4'h2;
  localparam logic [3:0] REG_UP_TIME    = 4'h3;
  localparam logic [3:0] REG_STATUS     = 4'h4;
  localparam logic [3:0] REG_LEVEL      = 4'h5;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h6;
  localparam logic [3:0] REG_IRQ_CLEAR  = 4'h7;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h8;

  // Status and event bit positions
  localparam int STATUS_ACTIVE_BIT = 0;
  localparam int STATUS_FAN_BIT    = 1;
  localparam int STATUS_HOLD_BIT   = 2;
  localparam int EVT_START_BIT     = 0;
  localparam int EVT_FLOOR_BIT     = 1;
  localparam int EVT_RECOVER_BIT   = 2;
  localparam int EVT_COUNT         = 3;

  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_RAMP_DOWN,
    ST_AT_FLOOR,
    ST_RECOVER
  } limiter_state_t;

endpackage

// ===== overload_limiter_properties.sv
`timescale 1ns/1ps
module overload_limiter_checker
  import overload_pkg::*;
#(
  parameter int          TICK_DIV = 4,
  parameter logic [15:0] STEP     = 16'h0004
) (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [15:0] nominal_current_ceiling,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] reduced_limit_level,
  input wire logic        limit_reduction_active,
  input wire logic        irq
);
  logic [15:0] prev_level;
  logic [15:0] level_diff;
  int          gap;
  // Last level and quiet-cycle count, kept so step size and spacing need no $past
  always_ff @(posedge clk_sys) begin
    prev_level <= reduced_limit_level;
    gap        <= (reduced_limit_level != prev_level) ? 0 : ((gap < 1000) ? gap + 1 : gap);
  end
  // Magnitude of the last change
  assign level_diff = (reduced_limit_level > prev_level) ? reduced_limit_level - prev_level
                                                         : prev_level - reduced_limit_level;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_reset_out;
    disable iff (1'b0) !reset_n |=> reduced_limit_level == 16'h0000 && !limit_reduction_active && !irq;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_unmapped;
    reg_rd && reg_addr > REG_IRQ_ENABLE |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cap;
    limit_reduction_active |-> reduced_limit_level <= nominal_current_ceiling;
  endproperty
  a_cap: assert property (p_cap) else $error("limit above ceiling");
  property p_idle_full;
    $past(reset_n, 3) && $past(reset_n, 2) && $past(reset_n) && !limit_reduction_active
      |-> reduced_limit_level == nominal_current_ceiling;
  endproperty
  a_idle_full: assert property (p_idle_full) else $error("limit reduced while inactive");
  property p_rise_full;
    $rose(limit_reduction_active) |-> $past(reduced_limit_level) == nominal_current_ceiling;
  endproperty
  a_rise_full: assert property (p_rise_full) else $error("limit fell before hold expired");
  property p_tick_step;
    limit_reduction_active && reduced_limit_level != prev_level |-> gap >= TICK_DIV - 1;
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("limit moved between ticks");
  property p_step_size;
    limit_reduction_active && $past(limit_reduction_active) |-> level_diff <= STEP;
  endproperty
  a_step_size: assert property (p_step_size) else $error("ramp step too large");
  c_rise: cover property ($rose(limit_reduction_active));
  c_fall: cover property ($fell(limit_reduction_active));
  c_irq: cover property ($rose(irq));
endmodule
bind overload_inverse_time_limiter overload_limiter_checker #(.TICK_DIV(TICK_DIV)) chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .nominal_current_ceiling(nominal_current_ceiling),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reduced_limit_level(reduced_limit_level),
  .limit_reduction_active(limit_reduction_active), .irq(irq));

// ===== current_loop_model.sv
`timescale 1ns/1ps
module current_loop_model
  import overload_pkg::*;
#(
  parameter logic [15:0] CEILING = PEAK_NORMAL
) (
  input  wire logic [15:0] demand,
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [15:0] reduced_limit_level,
  output logic      [15:0] motor_current,
  output logic      [15:0] nominal_current_ceiling
);
  // Current loop: motor follows demand but is held at the limit, so it sits on the floor too
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      motor_current <= 16'h0000;
    end else begin
      motor_current <= (demand > reduced_limit_level) ? reduced_limit_level : demand;
    end
  end
  // Current-limit function gives a fixed ceiling
  assign nominal_current_ceiling = CEILING;
endmodule

// ===== test_overload_inverse_time_limiter.sv
`timescale 1ns/1ps
module test_overload_inverse_time_limiter;
  import overload_pkg::*;
  localparam int          DIV    = 4;
  localparam logic [15:0] DEF[4] = '{THRESHOLD_RESET, HOLD_RESET, DOWN_RESET, UP_RESET};
  localparam logic [15:0] LIM[8] = '{THRESHOLD_MAX, THRESHOLD_MIN, HOLD_MAX, HOLD_MIN,
                                     DOWN_MAX, DOWN_MIN, UP_MAX, UP_MIN};
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        fan     = 1'b0;
  logic [15:0] demand  = 16'h0000;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_d = 1'b0;
  logic [15:0] reg_rdata, level, current, ceiling, r;
  logic        active, irq;
  logic [15:0] exp_q[$];
  logic [15:0] thr = THRESHOLD_RESET;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n;
  integer      seed = 32'h592b36ab;
  always #12.5 clk_sys = ~clk_sys;
  current_loop_model loop_i (.demand(demand), .clk_sys(clk_sys), .reset_n(reset_n),
    .reduced_limit_level(level), .motor_current(current), .nominal_current_ceiling(ceiling));
  overload_inverse_time_limiter #(.TICK_DIV(DIV)) uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .motor_current(current), .nominal_current_ceiling(ceiling), .fan_pump_load_mode(fan),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reduced_limit_level(level), .limit_reduction_active(active), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Expected read value is queued; the monitor compares it in the answer slot
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a; reg_rd <= 1'b1; exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  // Bounded wait: 0 active set, 1 level on floor, 2 active clear
  task wait_for(input int kind, output int k);
    k = 0;
    do begin @(posedge clk_sys); #1; k++; end
    while (k < 30000 && !((kind == 0 && active === 1'b1) || (kind == 1 && level === thr)
           || (kind == 2 && active === 1'b0)));
  endtask
  // Tick count allows four ticks of slack for tick phase and the current loop lag
  task near(input string name, input int k, input int ticks);
    check(name, 16'(k >= DIV * (ticks - 4) && k <= DIV * (ticks + 4)), 16'h0001);
  endtask
  function automatic int hold_ticks(input logic [15:0] peak, input int tenths);
    int exc;
    exc = PEAK_NORMAL - thr;
    return ((int'(peak) - int'(thr)) * tenths * TICKS_PER_TENTH + exc - 1) / exc;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Read monitor and run time limit
  always @(posedge clk_sys) begin
    if (rd_d) check("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
    cycles++;
    if (cycles == 90000) begin n_errors++; end_sim(); end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check("active", {15'h0000, active}, 16'h0000);
    check("level", level, PEAK_NORMAL);
    for (int i = 0; i < 4; i++) rd(4'(i), DEF[i]);
    rd(REG_STATUS, 16'h0000);
    rd(4'hF, 16'h0000);
    rd(REG_IRQ_CLEAR, 16'h0000);
    wr(REG_LEVEL, 16'h0000);
    rd(REG_LEVEL, PEAK_NORMAL);
    for (int i = 0; i < 8; i++) begin
      wr(4'(i / 2), i[0] ? 16'h0000 : 16'hFFFF);
      rd(4'(i / 2), LIM[i]);
    end
    r = THRESHOLD_MIN + 16'($random(seed) & 32'h1FFF);
    wr(REG_THRESHOLD, r);
    rd(REG_THRESHOLD, r);
    wr(REG_THRESHOLD, thr);
    wr(REG_IRQ_ENABLE, 16'h0007);
    rd(REG_IRQ_ENABLE, 16'h0007);
    $display("test registers done");
    // Full overload at the ceiling: hold, ramp to floor, then recover
    @(posedge clk_sys);
    demand <= 16'hFFFF;
    wait_for(0, n);
    near("hold span", n, hold_ticks(PEAK_NORMAL, HOLD_MIN));
    rd(REG_IRQ_STATUS, 16'h0001);
    check("irq on", {15'h0000, irq}, 16'h0001);
    wait_for(1, n);
    near("down ramp", n, (PEAK_NORMAL - thr) / ((PEAK_NORMAL - thr) / (DOWN_MIN * 100)));
    demand <= 16'h0000;
    wait_for(2, n);
    near("up ramp", n, (PEAK_NORMAL - thr) / ((PEAK_NORMAL - thr) / (UP_MIN * 100)));
    check("level full", level, PEAK_NORMAL);
    rd(REG_IRQ_STATUS, 16'h0007);
    wr(REG_IRQ_CLEAR, 16'h0007);
    rd(REG_IRQ_STATUS, 16'h0000);
    check("irq off", {15'h0000, irq}, 16'h0000);
    $display("test overload done");
    // Fan mode, masked; let the excess sum drain first so the fan hold starts empty
    wr(REG_IRQ_ENABLE, 16'h0000);
    repeat (DIV * 1100) @(posedge clk_sys);
    fan <= 1'b1;
    demand <= 16'hFFFF;
    wait_for(0, n);
    near("fan hold", n, hold_ticks(PEAK_FAN_PUMP, HOLD_FAN_PUMP));
    rd(REG_STATUS, 16'h0007);
    rd(REG_IRQ_STATUS, 16'h0001);
    check("irq masked", {15'h0000, irq}, 16'h0000);
    wr(REG_IRQ_ENABLE, 16'h0001);
    repeat (2) @(posedge clk_sys);
    #1;
    check("irq unmasked", {15'h0000, irq}, 16'h0001);
    $display("test fan mode done");
    end_sim();
  end
endmodule
